// ### scg_clock_gen.sv
// Purpose: main, peripheral and auxiliary clocks, frequency loop, crystal watch
// Assumes: source clock inputs are synchronous levels, slower than clk/2
// Notes: clock outputs are registered; switching waits for a low output, except when leaving a faulted crystal
`timescale 1ns/10ps
module scg_clock_gen
   import scg_pkg::*;
#(
   parameter int FAULT_CYCLES = XTAL_FAULT_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic dco_clk_in,
   input wire logic internal_rc_reference_osc_clk_in,
   input wire logic xtal_clk_in,
   input wire logic vlo_clk_in,
   input wire logic mod_clk_in,
   input wire logic [1:0] main_src_sel,
   input wire logic [MAIN_DIV_W-1:0] main_div_sel,
   input wire logic [SUB_DIV_W-1:0] sub_div_sel,
   input wire logic aux_src_internal_rc_reference_osc,
   input wire logic crystal_enable,
   input wire logic [1:0] port_four_function_select,
   input wire logic fll_enable,
   input wire logic fll_ref_external,
   input wire logic [FLL_CNT_W-1:0] fll_multiplier,
   output logic main_clk_out,
   output logic subsystem_peripheral_clock,
   output logic aux_clk_out,
   output logic modulation_fast_clock,
   output logic [TRIM_W-1:0] dco_trim,
   output logic fll_locked,
   output logic crystal_fault,
   output scg_src_t main_src_active
);
   localparam int FCW = $clog2(FAULT_CYCLES + 1);

   logic dco_q, internal_rc_reference_osc_q, xtal_q, vlo_q;
   logic dco_edge, internal_rc_reference_osc_edge, xtal_edge, vlo_edge;
   logic dco_rise, internal_rc_reference_osc_rise, xtal_rise;
   logic xtal_usable;
   logic [FCW-1:0] fault_cnt;
   scg_src_t next_main_src;
   logic main_edge;
   logic main_toggle, main_boundary;
   logic aux_sel_internal_rc_reference_osc, aux_sel_q;
   logic aux_edge, aux_boundary;
   logic ref_rise;
   logic [FLL_CNT_W-1:0] dco_cnt;
   logic edges_armed;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dco_q <= 1'b0;
         internal_rc_reference_osc_q <= 1'b0;
         xtal_q <= 1'b0;
         vlo_q <= 1'b0;
      end else begin
         dco_q <= dco_clk_in;
         internal_rc_reference_osc_q <= internal_rc_reference_osc_clk_in;
         xtal_q <= xtal_clk_in;
         vlo_q <= vlo_clk_in;
      end
   end

   // first cycle after reset only loads the input stage, so no false edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         edges_armed <= 1'b0;
      end else begin
         edges_armed <= 1'b1;
      end
   end

   assign dco_edge = edges_armed && (dco_clk_in ^ dco_q);
   assign internal_rc_reference_osc_edge = edges_armed && (internal_rc_reference_osc_clk_in ^ internal_rc_reference_osc_q);
   assign xtal_edge = edges_armed && (xtal_clk_in ^ xtal_q);
   assign vlo_edge = edges_armed && (vlo_clk_in ^ vlo_q);
   assign dco_rise = edges_armed && dco_clk_in && !dco_q;
   assign internal_rc_reference_osc_rise = edges_armed && internal_rc_reference_osc_clk_in && !internal_rc_reference_osc_q;
   assign xtal_rise = edges_armed && xtal_clk_in && !xtal_q;

   // crystal counts only once its pins are routed and it is enabled
   assign xtal_usable = crystal_enable && (port_four_function_select == XTAL_PINS_SET)
      && !crystal_fault;

   // crystal watch: no edge for the fault window raises a fault
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_cnt <= '0;
         crystal_fault <= 1'b0;
      end else if (!crystal_enable || xtal_edge) begin
         fault_cnt <= '0;
         crystal_fault <= 1'b0;
      end else if (fault_cnt == FCW'(FAULT_CYCLES - 1)) begin
         crystal_fault <= 1'b1;
      end else begin
         fault_cnt <= fault_cnt + FCW'(1);
      end
   end

   // main source: requested crystal falls back to the RC reference
   always_comb begin
      case (main_src_sel)
         2'h0: next_main_src = SCG_SRC_DCO;
         2'h1: next_main_src = SCG_SRC_INTERNAL_RC_REFERENCE_OSC;
         2'h2: next_main_src = xtal_usable ? SCG_SRC_XTAL : SCG_SRC_INTERNAL_RC_REFERENCE_OSC;
         2'h3: next_main_src = SCG_SRC_VLO;
         default: next_main_src = SCG_SRC_DCO;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         main_src_active <= MAIN_SRC_RESET;
      // dead crystal may hold the output high forever: leave it at once
      end else if ((main_boundary && !main_toggle) || (main_src_active == SCG_SRC_XTAL && crystal_fault)) begin
         main_src_active <= next_main_src;
      end
   end

   always_comb begin
      case (main_src_active)
         SCG_SRC_DCO: main_edge = dco_edge;
         SCG_SRC_INTERNAL_RC_REFERENCE_OSC: main_edge = internal_rc_reference_osc_edge;
         SCG_SRC_XTAL: main_edge = xtal_edge;
         SCG_SRC_VLO: main_edge = vlo_edge;
         default: main_edge = 1'b0;
      endcase
   end

   scg_clk_div #(.DIVW(MAIN_DIV_W)) u_main_div (
      .clk(clk),
      .rst_n(rst_n),
      .edge_in(main_edge),
      .div_sel(main_div_sel),
      .clk_out(main_clk_out),
      .toggle(main_toggle),
      .at_boundary(main_boundary)
   );

   // peripheral clock counts main clock edges, so never faster
   scg_clk_div #(.DIVW(SUB_DIV_W)) u_sub_div (
      .clk(clk),
      .rst_n(rst_n),
      .edge_in(main_toggle),
      .div_sel(sub_div_sel),
      .clk_out(subsystem_peripheral_clock),
      .toggle(),
      .at_boundary()
   );

   assign aux_sel_internal_rc_reference_osc = aux_src_internal_rc_reference_osc || !xtal_usable;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_sel_q <= 1'b1;
      end else if ((aux_boundary && !aux_edge) || (!aux_sel_q && crystal_fault)) begin
         aux_sel_q <= aux_sel_internal_rc_reference_osc;
      end
   end

   assign aux_edge = aux_sel_q ? internal_rc_reference_osc_edge : xtal_edge;

   scg_clk_div #(.DIVW(MAIN_DIV_W)) u_aux_div (
      .clk(clk),
      .rst_n(rst_n),
      .edge_in(aux_edge),
      .div_sel(AUX_DIV),
      .clk_out(aux_clk_out),
      .toggle(),
      .at_boundary(aux_boundary)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         modulation_fast_clock <= 1'b0;
      end else begin
         modulation_fast_clock <= mod_clk_in;
      end
   end

   // frequency loop: count oscillator rises per reference period
   assign ref_rise = (fll_ref_external && xtal_usable) ? xtal_rise : internal_rc_reference_osc_rise;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dco_cnt <= '0;
      end else if (ref_rise) begin
         dco_cnt <= FLL_CNT_W'(dco_rise);
      end else if (dco_rise && dco_cnt != '1) begin
         dco_cnt <= dco_cnt + FLL_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dco_trim <= TRIM_RESET;
         fll_locked <= 1'b0;
      end else if (!fll_enable) begin
         fll_locked <= 1'b0;
      end else if (ref_rise) begin
         fll_locked <= (dco_cnt == fll_multiplier);
         if (dco_cnt < fll_multiplier && dco_trim != TRIM_MAX) begin
            dco_trim <= dco_trim + TRIM_W'(1);
         end else if (dco_cnt > fll_multiplier && dco_trim != TRIM_MIN) begin
            dco_trim <= dco_trim - TRIM_W'(1);
         end
      end
   end

   main_src_safe_a: assert property (@(posedge clk) disable iff (!rst_n)
      !$stable(main_src_active) |-> !main_clk_out || $past(crystal_fault))
      else $error("main source switched while clock high");
   main_src_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
      (main_boundary && !main_toggle && main_src_sel != 2'h2)
      |=> 2'(main_src_active) == $past(main_src_sel))
      else $error("main source did not follow selection");
   main_toggle_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
      !$stable(main_clk_out) |-> $past(main_edge))
      else $error("main clock moved without a source edge");
   sub_follows_main_a: assert property (@(posedge clk) disable iff (!rst_n)
      !$stable(subsystem_peripheral_clock) |-> !$stable(main_clk_out))
      else $error("peripheral clock moved without main edge");
   aux_src_fallback_a: assert property (@(posedge clk) disable iff (!rst_n)
      (crystal_fault && aux_boundary && !aux_edge) |=> aux_sel_q)
      else $error("auxiliary clock kept faulty crystal");
   fault_raise_a: assert property (@(posedge clk) disable iff (!rst_n)
      (crystal_enable && !xtal_edge && fault_cnt == FCW'(FAULT_CYCLES - 1)) |=> crystal_fault)
      else $error("crystal fault not raised after timeout");
   pins_gate_xtal_a: assert property (@(posedge clk) disable iff (!rst_n)
      (main_src_sel == 2'h2 && port_four_function_select != XTAL_PINS_SET
      && main_boundary && !main_toggle) |=> main_src_active == SCG_SRC_INTERNAL_RC_REFERENCE_OSC)
      else $error("crystal used without pin routing");
   fll_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      (fll_enable && ref_rise && dco_cnt < fll_multiplier && dco_trim != TRIM_MAX)
      |=> dco_trim == $past(dco_trim) + TRIM_W'(1))
      else $error("trim did not rise on slow oscillator");
   fll_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !fll_enable |=> $stable(dco_trim) && !fll_locked)
      else $error("trim moved while loop disabled");

   lock_seen_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(fll_locked));
   fault_seen_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(crystal_fault));
   src_switch_c: cover property (@(posedge clk) disable iff (!rst_n) !$stable(main_src_active));
   sub_toggle_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(subsystem_peripheral_clock));
endmodule : scg_clock_gen

// ### scg_pkg.sv
// Purpose: constants and types for the system clock generator
// Assumes: one 50 MHz clock, all source clock inputs sampled as levels
// Notes: source clocks must be well below half the sampling rate
package scg_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int XTAL_FAULT_US = 100;
   localparam int XTAL_FAULT_CYCLES = XTAL_FAULT_US * 1000 / CLK_PERIOD_NS;
   localparam int MAIN_DIV_W = 3;
   localparam int SUB_DIV_W = 2;
   localparam int FLL_CNT_W = 10;
   localparam int TRIM_W = 9;
   localparam logic [TRIM_W-1:0] TRIM_RESET = 9'h100;
   localparam logic [TRIM_W-1:0] TRIM_MAX = 9'h1FF;
   localparam logic [TRIM_W-1:0] TRIM_MIN = 9'h000;
   localparam logic [MAIN_DIV_W-1:0] AUX_DIV = 3'h0;
   localparam logic [1:0] XTAL_PINS_SET = 2'h3;

   typedef enum logic [1:0] {
      SCG_SRC_DCO,
      SCG_SRC_INTERNAL_RC_REFERENCE_OSC,
      SCG_SRC_XTAL,
      SCG_SRC_VLO
   } scg_src_t;

   localparam scg_src_t MAIN_SRC_RESET = SCG_SRC_DCO;
endpackage : scg_pkg

// ### scg_clk_div.sv
// Purpose: edge-counting clock divider with safe reload
// Assumes: edge_in pulses once per source edge, rise or fall
// Notes: divide by 2**div; new ratio loads only on a falling output
`timescale 1ns/10ps
module scg_clk_div #(
   parameter int DIVW = 3
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic edge_in,
   input wire logic [DIVW-1:0] div_sel,
   output logic clk_out,
   output logic toggle,
   output logic at_boundary
);
   localparam int CW = (2 ** DIVW) - 1;
   logic [DIVW-1:0] active_div;
   logic [CW-1:0] cnt;
   logic [CW:0] limit_wide;
   logic [CW-1:0] limit;
   logic wrap;

   assign limit_wide = ((CW+1)'(1) << active_div) - (CW+1)'(1);
   assign limit = limit_wide[CW-1:0];
   assign wrap = edge_in && (cnt == limit);
   assign toggle = wrap;
   assign at_boundary = !clk_out && (cnt == '0);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         clk_out <= 1'b0;
      end else if (wrap) begin
         cnt <= '0;
         clk_out <= ~clk_out;
      end else if (edge_in) begin
         cnt <= cnt + CW'(1);
      end
   end

   // ratio changes only after a full high phase ends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_div <= '0;
      end else if (wrap && clk_out) begin
         active_div <= div_sel;
      end
   end
endmodule : scg_clk_div

// ### tb_system_clock_generator.sv
// Purpose: self-checking bench for the system clock generator
// Assumes: source clocks are slow levels made here; crystal watch count set to 16
// Notes: driver queues expected results, a monitor at the falling edge compares them
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
$display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_system_clock_generator;
   import scg_pkg::*;
   typedef struct {int kind; logic [15:0] exp;} scg_note_t;
   logic clk = 0, rst_n = 0, xtal_run = 1;
   logic dco_clk_in = 0, internal_rc_reference_osc_clk_in = 0, xtal_clk_in = 0, vlo_clk_in = 0, mod_clk_in = 0;
   logic [1:0] main_src_sel = 2'h0, port_four_function_select = 2'h0;
   logic [MAIN_DIV_W-1:0] main_div_sel = 3'h0;
   logic [SUB_DIV_W-1:0] sub_div_sel = 2'h0;
   logic aux_src_internal_rc_reference_osc = 1, crystal_enable = 0, fll_enable = 0, fll_ref_external = 0;
   logic [FLL_CNT_W-1:0] fll_multiplier = 10'h3;
   logic main_clk_out, subsystem_peripheral_clock, aux_clk_out, modulation_fast_clock;
   logic fll_locked, crystal_fault, pm = 0, seen = 0;
   logic [TRIM_W-1:0] dco_trim;
   scg_src_t main_src_active;
   logic [31:0] seed = 32'hC245BCFC;
   int fail_count = 0, checks = 0, cyc = 0, cnt = 0, runts = 0, ph = 0;
   scg_note_t notes[$];
   string nm[10] = '{"main", "sub", "aux", "mod", "fault", "lock", "src", "trim", "trim_up", "trim_dn"};

   scg_clock_gen #(.FAULT_CYCLES(16)) i_dut (.clk(clk), .rst_n(rst_n), .dco_clk_in(dco_clk_in),
      .internal_rc_reference_osc_clk_in(internal_rc_reference_osc_clk_in), .xtal_clk_in(xtal_clk_in), .vlo_clk_in(vlo_clk_in),
      .mod_clk_in(mod_clk_in), .main_src_sel(main_src_sel), .main_div_sel(main_div_sel),
      .sub_div_sel(sub_div_sel), .aux_src_internal_rc_reference_osc(aux_src_internal_rc_reference_osc), .crystal_enable(crystal_enable),
      .port_four_function_select(port_four_function_select), .fll_enable(fll_enable),
      .fll_ref_external(fll_ref_external), .fll_multiplier(fll_multiplier),
      .main_clk_out(main_clk_out), .subsystem_peripheral_clock(subsystem_peripheral_clock),
      .aux_clk_out(aux_clk_out), .modulation_fast_clock(modulation_fast_clock), .dco_trim(dco_trim),
      .fll_locked(fll_locked), .crystal_fault(crystal_fault), .main_src_active(main_src_active));

   always #10 clk = ~clk;

   // source clocks: periods 4, 12, 20, 28 and 6 cycles
   always @(posedge clk) begin
      cnt <= cnt + 1;
      if (cnt % 2 == 0) dco_clk_in <= ~dco_clk_in;
      if (cnt % 6 == 0) internal_rc_reference_osc_clk_in <= ~internal_rc_reference_osc_clk_in;
      if (xtal_run && cnt % 10 == 0) xtal_clk_in <= ~xtal_clk_in;
      if (cnt % 14 == 0) vlo_clk_in <= ~vlo_clk_in;
      if (cnt % 3 == 0) mod_clk_in <= ~mod_clk_in;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic sig(input int k);
      case (k)
         0: return main_clk_out;
         1: return subsystem_peripheral_clock;
         2: return aux_clk_out;
         default: return modulation_fast_clock;
      endcase
   endfunction : sig

   function automatic logic [15:0] now_val(input int k);
      case (k)
         4: return 16'(crystal_fault);
         5: return 16'(fll_locked);
         6: return 16'(main_src_active);
         7: return 16'(dco_trim);
         8: return 16'(dco_trim > TRIM_RESET);
         default: return 16'(dco_trim < TRIM_RESET);
      endcase
   endfunction : now_val

   // period from second to third rising edge, so a pending ratio change has landed
   task automatic measure(input int k, output int per);
      int r, t, t0;
      logic p;
      r = 0;
      t = 0;
      t0 = 0;
      p = sig(k);
      while (r < 3 && t < 4000) begin
         @(negedge clk);
         t++;
         if (sig(k) === 1'b1 && p === 1'b0) begin
            r++;
            if (r == 2) t0 = t;
         end
         p = sig(k);
      end
      per = (r == 3) ? t - t0 : 0;
   endtask : measure

   task automatic expect_val(input int k, input logic [15:0] e);
      int t;
      notes.push_back('{k, e});
      t = 0;
      while (notes.size() != 0 && t < 5000) begin
         @(posedge clk);
         t++;
      end
   endtask : expect_val

   task automatic final_report;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   always begin : monitor
      scg_note_t nt;
      int per;
      logic [15:0] got;
      @(negedge clk);
      if (notes.size() != 0) begin
         nt = notes[0];
         if (nt.kind < 4) begin
            measure(nt.kind, per);
            got = 16'(per);
         end else begin
            got = now_val(nt.kind);
         end
         void'(notes.pop_front());
         `CHK(nm[nt.kind], nt.exp, got)
      end
   end

   // phases shorter than the fastest source half period are runts
   always @(negedge clk) begin
      if (rst_n && main_clk_out !== pm) begin
         if (seen && ph < 2) runts++;
         seen = 1;
         ph = 0;
      end
      ph++;
      pm = main_clk_out;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         final_report();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1;
      expect_val(6, 16'(MAIN_SRC_RESET));
      expect_val(7, 16'(TRIM_RESET));
      expect_val(5, 16'h0);
      expect_val(4, 16'h0);
      for (int d = 0; d < 8; d++) begin
         @(posedge clk);
         main_div_sel <= 3'(d);
         expect_val(0, 16'h4 << d);
      end
      @(posedge clk);
      main_div_sel <= 3'h0;
      expect_val(0, 16'h4);
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         sub_div_sel <= 2'(s);
         expect_val(1, 16'h4 << s);
      end
      @(posedge clk);
      main_div_sel <= 3'h2;
      expect_val(1, 16'h80);
      expect_val(3, 16'h6);
      @(posedge clk);
      main_div_sel <= 3'h0;
      crystal_enable <= 1;
      port_four_function_select <= 2'h1;
      main_src_sel <= 2'h2;
      expect_val(0, 16'hC);
      expect_val(6, 16'(SCG_SRC_INTERNAL_RC_REFERENCE_OSC));
      @(posedge clk);
      port_four_function_select <= XTAL_PINS_SET;
      aux_src_internal_rc_reference_osc <= 0;
      expect_val(0, 16'h14);
      expect_val(6, 16'(SCG_SRC_XTAL));
      expect_val(2, 16'h14);
      @(posedge clk);
      xtal_run <= 0;
      for (int t = 0; t < 60 && crystal_fault !== 1'b1; t++) @(posedge clk);
      expect_val(4, 16'h1);
      expect_val(0, 16'hC);
      expect_val(6, 16'(SCG_SRC_INTERNAL_RC_REFERENCE_OSC));
      expect_val(2, 16'hC);
      @(posedge clk);
      xtal_run <= 1;
      repeat (30) @(posedge clk);
      expect_val(4, 16'h0);
      @(posedge clk);
      main_src_sel <= 2'h3;
      aux_src_internal_rc_reference_osc <= 1;
      expect_val(0, 16'h1C);
      expect_val(2, 16'hC);
      @(posedge clk);
      main_src_sel <= 2'h1;
      fll_enable <= 1;
      expect_val(0, 16'hC);
      repeat (200) @(posedge clk);
      expect_val(5, 16'h1);
      seed = lfsr(seed);
      @(posedge clk);
      fll_multiplier <= 10'(4 + seed[2:0]);
      repeat (200) @(posedge clk);
      expect_val(8, 16'h1);
      expect_val(5, 16'h0);
      @(posedge clk);
      fll_multiplier <= 10'h1;
      repeat (400) @(posedge clk);
      expect_val(9, 16'h1);
      @(posedge clk);
      fll_ref_external <= 1;
      fll_multiplier <= 10'h5;
      repeat (300) @(posedge clk);
      expect_val(5, 16'h1);
      @(posedge clk);
      fll_enable <= 0;
      repeat (4) @(posedge clk);
      expect_val(5, 16'h0);
      `CHK("runt", 0, runts)
      final_report();
   end
endmodule : tb_system_clock_generator
